// *** include/pfta_pkg.sv ***
// Package for the program flash table access unit: register map, fields, timing and types.
package pfta_pkg;

  // ****************************************
  // Register offsets (special function space)
  // ****************************************
  localparam logic [11:0] ADDR_MEM_CTRL   = 12'hfa6;
  localparam logic [11:0] ADDR_UNLOCK_KEY = 12'hfa7;
  localparam logic [11:0] ADDR_TBL_LATCH  = 12'hff5;
  localparam logic [11:0] ADDR_TBL_LOW    = 12'hff6;
  localparam logic [11:0] ADDR_TBL_HIGH   = 12'hff7;
  localparam logic [11:0] ADDR_TBL_UPPER  = 12'hff8;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int BIT_PROG_SEL  = 7;
  localparam int BIT_CFG_SEL   = 6;
  localparam int BIT_ERASE_EN  = 4;
  localparam int BIT_ABORT     = 3;
  localparam int BIT_PERMIT    = 2;
  localparam int BIT_LAUNCH    = 1;
  localparam int BIT_FETCH     = 0;

  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // ****************************************
  // Geometry and timing
  // ****************************************
  localparam int PTR_W        = 22;
  localparam int ADDR_W       = 21;
  localparam int HOLD_N       = 8;
  localparam int WRITE_SHIFT  = 3;
  localparam int ERASE_SHIFT  = 6;
  localparam int CLK_MHZ      = 250;
  localparam int PROG_TIME_US = 2000;
  localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {PTR_KEEP, PTR_POST_INC, PTR_POST_DEC, PTR_PRE_INC} pfta_ptr_mode_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} pfta_key_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_ERASE} pfta_state_t;

  typedef struct packed {
    logic           rd;
    logic           wr;
    pfta_ptr_mode_t mode;
  } pfta_table_op_t;

  typedef struct packed {
    logic        req;
    logic        erase;
    logic        cfg;
    logic [21:0] addr;
    logic [63:0] data;
  } pfta_flash_cmd_t;

endpackage

// *** hdl/pfta_core.sv ***
// Program flash table access unit: table latch, pointer, holding registers, timed write/erase.
`timescale 1ns/10ps
// What this block does
// - Reads one byte per table read; programs 8-byte blocks; erases 64-byte rows.
// - No bulk erase path exists; only row erase can be launched.
// - Fetch stall is held during a timed cycle; the timer ends it.
// - Any byte value is accepted into the array; decoding is the core's job.
// - All table transfers pass through the 8-bit table latch.
// - Table writes fill one of eight holding registers chosen by pointer bits 2:0.
// - Any byte address works; instruction alignment is the software's duty.
// - Unlock key is not stored and reads as zero; used only for launch.
// - Program-space select set targets program flash; clear targets data EEPROM for fetch, configuration space for timed cycles.
// - Configuration-space select overrides program-space select for timed cycles; the fetch trigger ignores it.
// - Erase enable makes the next launch a row erase; completion clears it.
// - Store permit gates all write and erase cycles; clear after reset.
// - Reset during a timed cycle sets the store abort flag.
// - Store abort leaves both space select bits untouched.
// - Launch bit set by software only; hardware clears it at completion.
// - Completion sets the done flag; software clears it.
// - Fetch trigger reads EEPROM for one cycle, self-clears, blocked when program select set.
// - Table pointer is 22 bits from three byte registers.
// - Pointer modes keep, post-inc, post-dec, pre-inc affect only low 21 bits.
// - Table read uses all 22 pointer bits.
// - Timed write uses pointer bits 21:3 for the 8-byte block.
// - Row erase uses pointer bits 21:6 and ignores 5:0.
// - Launch accepted only right after writes of 55h then AAh to the key.
// - Each timed cycle stalls the core for about 2 ms.
module pfta_core #(
  parameter int PROG_CYCLES = pfta_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  // Reset causes seen at the previous reset, from the reset controller
  input  wire logic                     abort_reset_cause,
  // Register port from the core
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [11:0]              reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  // Table instruction strobes
  input  wire pfta_pkg::pfta_table_op_t table_op,
  // Program flash array
  output pfta_pkg::pfta_flash_cmd_t     flash_cmd,
  input  wire logic                     flash_rd_ack,
  input  wire logic [15:0]              flash_rd_word,
  output logic      [21:0]              flash_rd_addr,
  // Data EEPROM read request and core side
  output logic                          ee_read_pulse,
  output logic                          fetch_stall,
  output logic                          nvm_done_irq_flag,
  input  wire logic                     nvm_done_irq_clear
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic                   prog_sel;
    logic                   cfg_sel;
    logic                   erase_en;
    logic                   abort;
    logic                   permit;
    logic                   launch;
    logic                   fetch;
    logic [7:0]             latch;
    logic [21:0]            ptr;
    logic [7:0][7:0]        hold;
    pfta_pkg::pfta_key_t    key;
    pfta_pkg::pfta_state_t  st;
    logic [31:0]            timer;
    logic                   rd_pend;
    logic                   rd_post;
    logic                   rd_dec;
    logic                   done;
    logic                   abort_sync;
    pfta_pkg::pfta_flash_cmd_t cmd;
    logic                   first;
  } pfta_state_reg_t;

  pfta_state_reg_t s_reg;
  pfta_state_reg_t s_next;
  logic [20:0]     ptr_lo_inc;
  logic [20:0]     ptr_lo_dec;

  assign ptr_lo_inc = s_reg.ptr[20:0] + 21'h000001;
  assign ptr_lo_dec = s_reg.ptr[20:0] - 21'h000001;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.cmd.req = 1'b0;
    s_next.fetch = 1'b0;
    s_next.first = 1'b0;
    // Besides software writes and a reset during a timed cycle, the reset cause captured on the first cycle raises the abort flag.
    if (s_reg.first && abort_reset_cause) begin
      s_next.abort = 1'b1;
    end
    // Register writes; the key register keeps no value, only the unlock progress.
    if (reg_wr) begin
      if (reg_addr != pfta_pkg::ADDR_UNLOCK_KEY) begin
        s_next.key = pfta_pkg::KEY_IDLE;
      end
      case (reg_addr)
        pfta_pkg::ADDR_MEM_CTRL: begin
          if (s_reg.st == pfta_pkg::ST_IDLE) begin
            s_next.prog_sel = reg_wdata[pfta_pkg::BIT_PROG_SEL];
            s_next.cfg_sel  = reg_wdata[pfta_pkg::BIT_CFG_SEL];
            s_next.erase_en = reg_wdata[pfta_pkg::BIT_ERASE_EN];
            s_next.abort    = reg_wdata[pfta_pkg::BIT_ABORT];
            s_next.permit   = reg_wdata[pfta_pkg::BIT_PERMIT];
            if (reg_wdata[pfta_pkg::BIT_FETCH] && !reg_wdata[pfta_pkg::BIT_PROG_SEL]
                && !s_reg.prog_sel) begin
              s_next.fetch = 1'b1;
            end
            // Zero writes to the launch bit are ignored; a set needs permit and unlock.
            if (reg_wdata[pfta_pkg::BIT_LAUNCH] && reg_wdata[pfta_pkg::BIT_PERMIT]
                && s_reg.permit && s_reg.key == pfta_pkg::KEY_ARMED) begin
              s_next.launch  = 1'b1;
              s_next.timer   = 32'(PROG_CYCLES);
              s_next.cmd.req = 1'b1;
              s_next.cmd.cfg = reg_wdata[pfta_pkg::BIT_CFG_SEL]
                               | ~reg_wdata[pfta_pkg::BIT_PROG_SEL];
              s_next.cmd.data = s_reg.hold;
              if (reg_wdata[pfta_pkg::BIT_ERASE_EN]) begin
                s_next.st = pfta_pkg::ST_ERASE;
                s_next.cmd.erase = 1'b1;
                s_next.cmd.addr = {s_reg.ptr[21:pfta_pkg::ERASE_SHIFT], 6'h00};
              end else begin
                s_next.st = pfta_pkg::ST_WRITE;
                s_next.cmd.erase = 1'b0;
                s_next.cmd.addr = {s_reg.ptr[21:pfta_pkg::WRITE_SHIFT], 3'h0};
              end
            end
            s_next.key = pfta_pkg::KEY_IDLE;
          end
        end
        pfta_pkg::ADDR_UNLOCK_KEY: begin
          if (reg_wdata == pfta_pkg::KEY_FIRST) begin
            s_next.key = pfta_pkg::KEY_GOT_FIRST;
          end else if (reg_wdata == pfta_pkg::KEY_SECOND
                       && s_reg.key == pfta_pkg::KEY_GOT_FIRST) begin
            s_next.key = pfta_pkg::KEY_ARMED;
          end else begin
            s_next.key = pfta_pkg::KEY_IDLE;
          end
        end
        pfta_pkg::ADDR_TBL_LATCH: s_next.latch = reg_wdata;
        pfta_pkg::ADDR_TBL_LOW:   s_next.ptr[7:0] = reg_wdata;
        pfta_pkg::ADDR_TBL_HIGH:  s_next.ptr[15:8] = reg_wdata;
        pfta_pkg::ADDR_TBL_UPPER: s_next.ptr[21:16] = reg_wdata[5:0];
        default: begin
        end
      endcase
    end
    // Table instructions are ignored while the core is stalled.
    if (s_reg.st == pfta_pkg::ST_IDLE && !s_reg.rd_pend) begin
      if (table_op.wr) begin
        s_next.hold[s_reg.ptr[2:0]] = s_reg.latch;
        case (table_op.mode)
          pfta_pkg::PTR_POST_INC: s_next.ptr[20:0] = ptr_lo_inc;
          pfta_pkg::PTR_POST_DEC: s_next.ptr[20:0] = ptr_lo_dec;
          pfta_pkg::PTR_PRE_INC: begin
            s_next.ptr[20:0] = ptr_lo_inc;
            s_next.hold[s_reg.ptr[2:0]] = s_reg.hold[s_reg.ptr[2:0]];
            s_next.hold[ptr_lo_inc[2:0]] = s_reg.latch;
          end
          default: begin
          end
        endcase
      end else if (table_op.rd) begin
        s_next.rd_pend = 1'b1;
        s_next.rd_post = table_op.mode == pfta_pkg::PTR_POST_INC
                         || table_op.mode == pfta_pkg::PTR_POST_DEC;
        s_next.rd_dec  = table_op.mode == pfta_pkg::PTR_POST_DEC;
        if (table_op.mode == pfta_pkg::PTR_PRE_INC) begin
          s_next.ptr[20:0] = ptr_lo_inc;
        end
      end
    end
    if (s_reg.rd_pend && flash_rd_ack) begin
      s_next.latch = s_reg.ptr[0] ? flash_rd_word[15:8] : flash_rd_word[7:0];
      s_next.rd_pend = 1'b0;
      if (s_reg.rd_post) begin
        s_next.ptr[20:0] = s_reg.rd_dec ? ptr_lo_dec : ptr_lo_inc;
      end
    end
    // Self-timed cycle; the timer alone ends the stall.
    if (s_reg.st != pfta_pkg::ST_IDLE) begin
      s_next.timer = s_reg.timer - 32'h00000001;
      if (s_reg.timer == 32'h00000001) begin
        s_next.st = pfta_pkg::ST_IDLE;
        s_next.launch = 1'b0;
        s_next.abort = 1'b0;
        s_next.done = 1'b1;
        if (s_reg.st == pfta_pkg::ST_ERASE) begin
          s_next.erase_en = 1'b0;
        end
      end
    end
    // A new completion wins over a clear in the same cycle.
    if (nvm_done_irq_clear && !(s_reg.st != pfta_pkg::ST_IDLE
                                && s_reg.timer == 32'h00000001)) begin
      s_next.done = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Select bits and the abort flag are kept across reset so a failed target stays visible.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.prog_sel <= s_reg.prog_sel;
      s_reg.cfg_sel  <= s_reg.cfg_sel;
      s_reg.abort    <= s_reg.abort | s_reg.launch;
      s_reg.first    <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    reg_rdata = 8'h00;
    case (reg_addr)
      pfta_pkg::ADDR_MEM_CTRL: reg_rdata = {s_reg.prog_sel, s_reg.cfg_sel, 1'b0, s_reg.erase_en,
                                           s_reg.abort, s_reg.permit, s_reg.launch, s_reg.fetch};
      pfta_pkg::ADDR_TBL_LATCH: reg_rdata = s_reg.latch;
      pfta_pkg::ADDR_TBL_LOW:   reg_rdata = s_reg.ptr[7:0];
      pfta_pkg::ADDR_TBL_HIGH:  reg_rdata = s_reg.ptr[15:8];
      pfta_pkg::ADDR_TBL_UPPER: reg_rdata = {2'h0, s_reg.ptr[21:16]};
      default: reg_rdata = 8'h00;
    endcase
  end

  assign flash_cmd         = s_reg.cmd;
  assign flash_rd_addr     = s_reg.ptr;
  assign ee_read_pulse     = s_reg.fetch;
  assign fetch_stall       = s_reg.st != pfta_pkg::ST_IDLE || s_reg.rd_pend;
  assign nvm_done_irq_flag = s_reg.done;

endmodule

// *** testbench/pfta_core_monitor.sv ***
// Checker for the program flash table access unit, bound to its ports.
`timescale 1ns/10ps
module pfta_core_monitor #(
  parameter int PROG_CYCLES = 20
) (
  // Clock and reset
  input wire logic                      clock,
  input wire logic                      rst_n,
  // Core side
  input wire logic [11:0]               reg_addr,
  input wire logic                      reg_wr,
  input wire logic [7:0]                reg_wdata,
  input wire logic [7:0]                reg_rdata,
  input wire pfta_pkg::pfta_table_op_t  table_op,
  // Array and status side
  input wire pfta_pkg::pfta_flash_cmd_t flash_cmd,
  input wire logic                      ee_read_pulse,
  input wire logic                      fetch_stall,
  input wire logic                      nvm_done_irq_flag,
  input wire logic                      nvm_done_irq_clear
);
  logic [31:0] stall_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // A second launch cannot hide inside a stall, so one counter covers every timed cycle.
  always_ff @(posedge clock) begin
    stall_cnt <= !rst_n ? 32'h0 : flash_cmd.req ? 32'h1 :
                 (fetch_stall && stall_cnt != 32'h0) ? stall_cnt + 32'h1 : 32'h0;
  end
  a_launch_stalls: assert property (flash_cmd.req |-> fetch_stall)
    else $error("launch without stall");
  a_launch_pulse: assert property (flash_cmd.req |=> !flash_cmd.req)
    else $error("launch request longer than one cycle");
  a_stall_holds: assert property (flash_cmd.req |=> fetch_stall [*8])
    else $error("timed cycle ended too early");
  a_timer_bound: assert property (stall_cnt <= PROG_CYCLES + 2)
    else $error("timed cycle overran its timer");
  a_launch_cause: assert property (flash_cmd.req |-> $past(reg_wr) &&
    $past(reg_addr) == pfta_pkg::ADDR_MEM_CTRL && $past(reg_wdata[pfta_pkg::BIT_LAUNCH]))
    else $error("launch without a control write");
  a_key_reads_zero: assert property (reg_addr == pfta_pkg::ADDR_UNLOCK_KEY |-> reg_rdata == 8'h00)
    else $error("key register read not zero");
  a_fetch_pulse: assert property (ee_read_pulse |=> !ee_read_pulse)
    else $error("eeprom read longer than one cycle");
  a_done_sticky: assert property (nvm_done_irq_flag && !nvm_done_irq_clear |=> nvm_done_irq_flag)
    else $error("done flag dropped without clear");
  a_done_at_end: assert property ($rose(nvm_done_irq_flag) |-> $past(fetch_stall) && !fetch_stall)
    else $error("done flag outside cycle end");
  a_read_stalls: assert property (table_op.rd && !fetch_stall |=> fetch_stall)
    else $error("table read did not stall");
  c_erase: cover property (flash_cmd.req && flash_cmd.erase);
  c_write: cover property (flash_cmd.req && !flash_cmd.erase);
  c_fetch: cover property (ee_read_pulse);
endmodule
bind pfta_core pfta_core_monitor #(.PROG_CYCLES(PROG_CYCLES)) pfta_core_monitor_inst (.*);

// *** testbench/pfta_flash_model.sv ***
// Behavioural program flash array answering table reads and timed cycles.
`timescale 1ns/10ps
module pfta_flash_model (
  // Clock, reset and answer delay
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic [3:0]                lat,
  // Unit side
  input  wire pfta_pkg::pfta_flash_cmd_t flash_cmd,
  input  wire logic                      fetch_stall,
  input  wire logic [21:0]               flash_rd_addr,
  output logic                           flash_rd_ack,
  output logic      [15:0]               flash_rd_word
);
  logic [7:0]  mem [256];
  logic        busy;
  logic [3:0]  cnt;
  logic [15:0] word;
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
  assign word = {mem[{flash_rd_addr[7:1], 1'b1}], mem[{flash_rd_addr[7:1], 1'b0}]};
  // Outside an answer the word is inverted, so a stale capture cannot match.
  assign flash_rd_word = flash_rd_ack ? word : ~word;
  always @(posedge clock) begin
    flash_rd_ack <= rst_n && fetch_stall && !busy && cnt == lat;
    cnt <= (fetch_stall && !busy && cnt != lat) ? cnt + 4'h1 : 4'h0;
    busy <= rst_n && (flash_cmd.req || busy && fetch_stall);
    for (int i = 0; i < 64; i++) begin
      if (rst_n && flash_cmd.req && flash_cmd.erase)
        mem[{flash_cmd.addr[7:6], i[5:0]}] <= 8'hff;
      if (rst_n && flash_cmd.req && !flash_cmd.erase && i < 8)
        mem[{flash_cmd.addr[7:3], i[2:0]}] <= flash_cmd.data[8*i +: 8];
    end
  end
endmodule

// *** testbench/tb_pfta_core.sv ***
// Self-checking bench for the program flash table access unit.
`timescale 1ns/10ps
module tb_pfta_core;
  logic                      clock, rst_n, abort_reset_cause, reg_wr, reg_rd, flash_rd_ack;
  logic                      ee_read_pulse, fetch_stall, nvm_done_irq_flag, nvm_done_irq_clear;
  logic [11:0]               reg_addr;
  logic [7:0]                reg_wdata, reg_rdata;
  logic [21:0]               flash_rd_addr;
  logic [15:0]               flash_rd_word;
  logic [3:0]                lat;
  pfta_pkg::pfta_table_op_t  table_op;
  pfta_pkg::pfta_flash_cmd_t flash_cmd;
  int                        n_errors = 0;
  int                        compares = 0;
  int                        cycles = 0;
  pfta_core #(.PROG_CYCLES(20)) pfta_core_inst (.*);
  pfta_flash_model pfta_flash_model_inst (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_rd <= 1'b0;
    table_op <= '0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_wr <= 1'b0;
    table_op <= '0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    // Read data is combinational on state that moves at this edge, so look once it settles.
    #1;
    check(reg_rdata & m, e);
  endtask
  task automatic settle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    table_op <= '0;
    repeat (2) @(posedge clock);
    #1;
    for (int k = 0; k < 100 && fetch_stall; k++) begin
      @(posedge clock);
      #1;
    end
    check(fetch_stall, 1'b0);
  endtask
  task automatic tbl(input logic r, input pfta_pkg::pfta_ptr_mode_t m, input logic [21:0] p);
    wr(pfta_pkg::ADDR_TBL_LOW, p[7:0]);
    wr(pfta_pkg::ADDR_TBL_HIGH, p[15:8]);
    wr(pfta_pkg::ADDR_TBL_UPPER, {2'b0, p[21:16]});
    reg_wr <= 1'b0;
    table_op <= '{rd: r, wr: !r, mode: m};
    @(posedge clock);
    settle();
  endtask
  task automatic launch(input logic [7:0] c, input logic e);
    // The launch needs the permit bit already set, so set up the fields first.
    wr(pfta_pkg::ADDR_MEM_CTRL, c & 8'hfd);
    wr(pfta_pkg::ADDR_UNLOCK_KEY, pfta_pkg::KEY_FIRST);
    wr(pfta_pkg::ADDR_UNLOCK_KEY, pfta_pkg::KEY_SECOND);
    wr(pfta_pkg::ADDR_MEM_CTRL, c);
    settle();
    check(nvm_done_irq_flag, e);
    nvm_done_irq_clear <= 1'b1;
    @(posedge clock);
    nvm_done_irq_clear <= 1'b0;
  endtask
  task automatic t_read();
    for (int m = 0; m < 4; m++) begin
      lat <= m[0] ? 4'h6 : 4'h1;
      tbl(1'b1, pfta_pkg::pfta_ptr_mode_t'(m), 22'h000113);
      rd(pfta_pkg::ADDR_TBL_LATCH, 8'hff, (m == 3 ? 8'h14 : 8'h13) ^ 8'h5a);
      rd(pfta_pkg::ADDR_TBL_LOW, 8'hff, m == 0 ? 8'h13 : m == 2 ? 8'h12 : 8'h14);
    end
    tbl(1'b1, pfta_pkg::PTR_POST_INC, 22'h3fffff);
    rd(pfta_pkg::ADDR_TBL_UPPER, 8'h3f, 8'h20);
    rd(pfta_pkg::ADDR_TBL_LATCH, 8'hff, 8'ha5);
  endtask
  task automatic t_write();
    for (int i = 0; i < 8; i++) begin
      wr(pfta_pkg::ADDR_TBL_LATCH, 8'hc0 + i[7:0]);
      tbl(1'b0, pfta_pkg::PTR_KEEP, 22'h000040 + i[21:0]);
    end
    launch(8'h86, 1'b1);
    rd(pfta_pkg::ADDR_MEM_CTRL, 8'h0a, 8'h00);
    tbl(1'b1, pfta_pkg::PTR_KEEP, 22'h000043);
    rd(pfta_pkg::ADDR_TBL_LATCH, 8'hff, 8'hc3);
  endtask
  task automatic t_erase();
    tbl(1'b1, pfta_pkg::PTR_KEEP, 22'h000047);
    launch(8'h96, 1'b1);
    rd(pfta_pkg::ADDR_MEM_CTRL, 8'h12, 8'h00);
    tbl(1'b1, pfta_pkg::PTR_KEEP, 22'h00007f);
    rd(pfta_pkg::ADDR_TBL_LATCH, 8'hff, 8'hff);
  endtask
  task automatic t_refused();
    tbl(1'b1, pfta_pkg::PTR_KEEP, 22'h000080);
    wr(pfta_pkg::ADDR_MEM_CTRL, 8'h86);
    settle();
    check(nvm_done_irq_flag, 1'b0);
    wr(pfta_pkg::ADDR_MEM_CTRL, 8'h80);
    launch(8'h82, 1'b0);
    tbl(1'b1, pfta_pkg::PTR_KEEP, 22'h000080);
    rd(pfta_pkg::ADDR_TBL_LATCH, 8'hff, 8'hda);
  endtask
  task automatic t_fetch(input logic [7:0] c, input int e);
    int n;
    n = 0;
    wr(pfta_pkg::ADDR_MEM_CTRL, 8'h00);
    wr(pfta_pkg::ADDR_MEM_CTRL, c);
    reg_wr <= 1'b0;
    repeat (3) begin
      @(negedge clock);
      n = n + (ee_read_pulse === 1'b1 ? 1 : 0);
    end
    check(n, e);
    rd(pfta_pkg::ADDR_MEM_CTRL, 8'h01, 8'h00);
  endtask
  task automatic t_abort();
    wr(pfta_pkg::ADDR_MEM_CTRL, 8'hc4);
    wr(pfta_pkg::ADDR_UNLOCK_KEY, pfta_pkg::KEY_FIRST);
    wr(pfta_pkg::ADDR_UNLOCK_KEY, pfta_pkg::KEY_SECOND);
    wr(pfta_pkg::ADDR_MEM_CTRL, 8'hc6);
    reg_wr <= 1'b0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b0;
    abort_reset_cause <= 1'b1;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    abort_reset_cause <= 1'b0;
    rd(pfta_pkg::ADDR_MEM_CTRL, 8'hc8, 8'hc8);
  endtask
  initial begin
    {rst_n, abort_reset_cause, reg_wr, reg_rd, nvm_done_irq_clear} = 5'h00;
    {reg_addr, reg_wdata, lat} = 24'h000001;
    table_op = '0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(pfta_pkg::ADDR_UNLOCK_KEY, 8'hff, 8'h00);
    rd(pfta_pkg::ADDR_MEM_CTRL, 8'h07, 8'h00);
    t_read();
    t_write();
    t_erase();
    t_refused();
    t_fetch(8'h01, 1);
    t_fetch(8'h81, 0);
    t_abort();
    complete_run();
  end
endmodule
